// ===== vmcfm_pkg.sv
/*
  Shared constants and types for the control-structure field map: encoding
  layout, field encodings, capability bits and the request and answer records.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package vmcfm_pkg;

  // ---------------------------------------------------------------------------
  // Encoding layout
  // ---------------------------------------------------------------------------
  localparam int unsigned ENC_HIGH_BIT  = 0;
  localparam int unsigned ENC_IDX_LSB   = 1;
  localparam int unsigned ENC_IDX_MSB   = 9;
  localparam int unsigned ENC_TYPE_LSB  = 10;
  localparam int unsigned ENC_TYPE_MSB  = 11;
  localparam int unsigned ENC_WIDTH_LSB = 13;
  localparam int unsigned ENC_WIDTH_MSB = 14;

  localparam logic [1:0] TYPE_CONTROL = 2'h0;
  localparam logic [1:0] TYPE_RO_DATA = 2'h1;
  localparam logic [1:0] TYPE_GUEST   = 2'h2;
  localparam logic [1:0] TYPE_HOST    = 2'h3;

  localparam logic [1:0] WIDTH_64 = 2'h1;
  localparam logic [1:0] WIDTH_32 = 2'h2;

  // ---------------------------------------------------------------------------
  // Encodings of the fields held here, all full-access but the high one of directory entry 3
  // ---------------------------------------------------------------------------
  localparam logic [31:0] ENC_LINEAR_XLAT_ROOT_PTR = 32'h0000_2040;
  localparam logic [31:0] ENC_POSTED_INT_TABLE     = 32'h0000_2042;
  localparam logic [31:0] ENC_SEC_EXIT_CONTROLS    = 32'h0000_2044;
  localparam logic [31:0] ENC_GUEST_PHYS_ADDR      = 32'h0000_2400;
  localparam logic [31:0] ENC_LINK_PTR             = 32'h0000_2800;
  localparam logic [31:0] ENC_DEBUG_CONTROL        = 32'h0000_2802;
  localparam logic [31:0] ENC_PAGE_ATTR            = 32'h0000_2804;
  localparam logic [31:0] ENC_EXT_FEATURE_ENABLE   = 32'h0000_2806;
  localparam logic [31:0] ENC_PERF_GLOBAL_CONTROL  = 32'h0000_2808;
  localparam logic [31:0] ENC_DIR_PTR_ENTRY_0      = 32'h0000_280A;
  localparam logic [31:0] ENC_DIR_PTR_ENTRY_3_HIGH = 32'h0000_2811;
  localparam logic [31:0] ENC_BOUND_CONFIG         = 32'h0000_2812;
  localparam logic [31:0] ENC_TRACE_CONTROL        = 32'h0000_2814;
  localparam logic [31:0] ENC_BRANCH_RECORD_CTRL   = 32'h0000_2816;
  localparam logic [31:0] ENC_SUPERVISOR_PROT_KEY  = 32'h0000_2818;

  // ---------------------------------------------------------------------------
  // Storage slots
  // ---------------------------------------------------------------------------
  localparam int unsigned NUM_SLOTS = 17;
  localparam logic [4:0]  SLOT_LXRP = 5'h00;
  localparam logic [4:0]  SLOT_PITA = 5'h01;
  localparam logic [4:0]  SLOT_SECX = 5'h02;
  localparam logic [4:0]  SLOT_GPA  = 5'h03;
  localparam logic [4:0]  SLOT_LINK = 5'h04;
  localparam logic [4:0]  SLOT_DBG  = 5'h05;
  localparam logic [4:0]  SLOT_PAT  = 5'h06;
  localparam logic [4:0]  SLOT_EFER = 5'h07;
  localparam logic [4:0]  SLOT_PERF = 5'h08;
  localparam logic [4:0]  SLOT_PDP0 = 5'h09;
  localparam logic [4:0]  SLOT_BND  = 5'h0D;
  localparam logic [4:0]  SLOT_TRC  = 5'h0E;
  localparam logic [4:0]  SLOT_BRC  = 5'h0F;
  localparam logic [4:0]  SLOT_PKEY = 5'h10;

  localparam logic [63:0] FIELD_RESET = 64'h0000_0000_0000_0000;

  // ---------------------------------------------------------------------------
  // Records
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic linear_xlat_feature;    // Enable execution control can be 1.
    logic ipi_virtualization;     // Interrupt virtualization can be 1.
    logic sec_exit_controls;      // Exit control activating secondary ones.
    logic extended_page_tables;   // Extended page tables can be enabled.
    logic entry_load_page_attr;
    logic exit_save_page_attr;
    logic entry_load_ext_feature;
    logic exit_save_ext_feature;
    logic entry_load_perf_global;
    logic entry_load_bound_cfg;
    logic exit_clear_bound_cfg;
    logic entry_load_trace_ctl;
    logic exit_clear_trace_ctl;
    logic entry_load_branch_rec;
    logic exit_clear_branch_rec;
    logic entry_load_prot_key;
  } vmcfm_caps_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] encoding;
    logic [63:0] wdata;
  } vmcfm_req_t;

  typedef enum logic [2:0] {
    VMCFM_CLS_CONTROL,
    VMCFM_CLS_RO_DATA,
    VMCFM_CLS_GUEST,
    VMCFM_CLS_HOST,
    VMCFM_CLS_OTHER
  } vmcfm_class_t;

  typedef struct packed {
    logic         valid;
    logic         error;      // Unsupported field or write to read-only data, nothing stored or read.
    logic         high_half;
    vmcfm_class_t fclass;
    logic [63:0]  rdata;
  } vmcfm_rsp_t;

  typedef struct packed {
    logic         hit;        // Encoding names a field held here.
    logic         exists;     // Field exists on this configuration.
    logic         read_only;
    logic         high_half;
    vmcfm_class_t fclass;
    logic [4:0]   slot;
  } vmcfm_dec_t;

endpackage : vmcfm_pkg

`default_nettype wire

// ===== vmcfm_decode.sv
/*
  Combinational encoding decoder: classifies an encoding by type and width
  and maps it to a storage slot with its existence condition.
  Assumes a capability vector that is stable while requests are decoded.
*/
`default_nettype none

module vmcfm_decode (
  input  wire logic [31:0]           i_encoding, // Field encoding
  input  wire vmcfm_pkg::vmcfm_caps_t i_caps,    // Supported settings
  output var  vmcfm_pkg::vmcfm_dec_t  o_dec      // Decode result
);

  logic [1:0]  ftype;
  logic [1:0]  fwidth;
  logic [31:0] full_enc;
  logic [3:0]  pdp_off;

  always_comb begin
    ftype    = i_encoding[vmcfm_pkg::ENC_TYPE_MSB:vmcfm_pkg::ENC_TYPE_LSB];
    fwidth   = i_encoding[vmcfm_pkg::ENC_WIDTH_MSB:vmcfm_pkg::ENC_WIDTH_LSB];
    // Both halves share one full encoding; bit 0 picks the upper half.
    full_enc = {i_encoding[31:1], 1'b0};
    pdp_off  = 4'(i_encoding[4:0] - vmcfm_pkg::ENC_DIR_PTR_ENTRY_0[4:0]);
    o_dec    = '0;
    o_dec.high_half = i_encoding[vmcfm_pkg::ENC_HIGH_BIT];
    case (ftype)
      vmcfm_pkg::TYPE_CONTROL: o_dec.fclass = vmcfm_pkg::VMCFM_CLS_CONTROL;
      vmcfm_pkg::TYPE_RO_DATA: o_dec.fclass = vmcfm_pkg::VMCFM_CLS_RO_DATA;
      vmcfm_pkg::TYPE_GUEST:   o_dec.fclass = vmcfm_pkg::VMCFM_CLS_GUEST;
      vmcfm_pkg::TYPE_HOST:    o_dec.fclass = vmcfm_pkg::VMCFM_CLS_HOST;
      default:                 o_dec.fclass = vmcfm_pkg::VMCFM_CLS_OTHER;
    endcase
    // 32-bit fields accept only even encodings, and none are held here.
    if (fwidth == vmcfm_pkg::WIDTH_64) begin
      o_dec.hit = 1'b1;
      case (full_enc)
        vmcfm_pkg::ENC_LINEAR_XLAT_ROOT_PTR: begin
          o_dec.slot   = vmcfm_pkg::SLOT_LXRP;
          o_dec.exists = i_caps.linear_xlat_feature;
        end
        vmcfm_pkg::ENC_POSTED_INT_TABLE: begin
          o_dec.slot   = vmcfm_pkg::SLOT_PITA;
          o_dec.exists = i_caps.ipi_virtualization;
        end
        vmcfm_pkg::ENC_SEC_EXIT_CONTROLS: begin
          o_dec.slot   = vmcfm_pkg::SLOT_SECX;
          o_dec.exists = i_caps.sec_exit_controls;
        end
        vmcfm_pkg::ENC_GUEST_PHYS_ADDR: begin
          o_dec.slot      = vmcfm_pkg::SLOT_GPA;
          o_dec.read_only = 1'b1;
          o_dec.exists    = i_caps.extended_page_tables;
        end
        vmcfm_pkg::ENC_LINK_PTR: begin
          o_dec.slot   = vmcfm_pkg::SLOT_LINK;
          o_dec.exists = 1'b1;
        end
        vmcfm_pkg::ENC_DEBUG_CONTROL: begin
          o_dec.slot   = vmcfm_pkg::SLOT_DBG;
          o_dec.exists = 1'b1;
        end
        vmcfm_pkg::ENC_PAGE_ATTR: begin
          o_dec.slot   = vmcfm_pkg::SLOT_PAT;
          o_dec.exists = i_caps.entry_load_page_attr | i_caps.exit_save_page_attr;
        end
        vmcfm_pkg::ENC_EXT_FEATURE_ENABLE: begin
          o_dec.slot   = vmcfm_pkg::SLOT_EFER;
          o_dec.exists = i_caps.entry_load_ext_feature
                       | i_caps.exit_save_ext_feature;
        end
        vmcfm_pkg::ENC_PERF_GLOBAL_CONTROL: begin
          o_dec.slot   = vmcfm_pkg::SLOT_PERF;
          o_dec.exists = i_caps.entry_load_perf_global;
        end
        vmcfm_pkg::ENC_BOUND_CONFIG: begin
          o_dec.slot   = vmcfm_pkg::SLOT_BND;
          o_dec.exists = i_caps.entry_load_bound_cfg | i_caps.exit_clear_bound_cfg;
        end
        vmcfm_pkg::ENC_TRACE_CONTROL: begin
          o_dec.slot   = vmcfm_pkg::SLOT_TRC;
          o_dec.exists = i_caps.entry_load_trace_ctl | i_caps.exit_clear_trace_ctl;
        end
        vmcfm_pkg::ENC_BRANCH_RECORD_CTRL: begin
          o_dec.slot   = vmcfm_pkg::SLOT_BRC;
          o_dec.exists = i_caps.entry_load_branch_rec
                       | i_caps.exit_clear_branch_rec;
        end
        vmcfm_pkg::ENC_SUPERVISOR_PROT_KEY: begin
          o_dec.slot   = vmcfm_pkg::SLOT_PKEY;
          o_dec.exists = i_caps.entry_load_prot_key;
        end
        default: begin
          if (i_encoding >= vmcfm_pkg::ENC_DIR_PTR_ENTRY_0
              && i_encoding <= vmcfm_pkg::ENC_DIR_PTR_ENTRY_3_HIGH) begin
            o_dec.slot   = 5'(vmcfm_pkg::SLOT_PDP0 + 5'(pdp_off[3:1]));
            o_dec.exists = i_caps.extended_page_tables;
          end else begin
            o_dec.hit = 1'b0;
          end
        end
      endcase
    end
  end

endmodule // vmcfm_decode

`default_nettype wire

// ===== vmcfm_field_map.sv
/*
  Storage and access logic for the 64-bit control, read-only data and guest
  fields of the virtual-machine control structure.
  Assumes the requester holds one request per cycle and reads the answer one
  cycle later; the capability vector is static configuration.
*/
// Functional notes
// - Type bits 1 mean read-only data field.
// - Type bits 2 mean guest-state field.
// - Index bits 9:1 select field in group.
// - Each field has full and high encodings.
// - Guest physical address exists with page tables.
// - Translation root pointer needs its enable control.
// - Posted identifier table needs interrupt virtualization.
// - Secondary exit controls need activating exit control.
// - Link pointer and debug copy always exist.
// - Attribute and feature copies need load or save.
// - Perf control copy needs its entry load.
// - Four directory entries need extended page tables.
// - Bound and trace copies need load or clear.
// - Branch record copy needs load or clear.
// - Protection key copy needs its entry load.
// - Type bits 3 mean host-state field.
// - Width bits 14:13 give field width.
`default_nettype none

module vmcfm_field_map (
  input  wire logic                   I_CLK,        // 20 MHz clock
  input  wire logic                   I_RST_N,      // Synchronous reset, low
  input  wire vmcfm_pkg::vmcfm_caps_t I_CAPS,       // Supported settings
  input  wire vmcfm_pkg::vmcfm_req_t  I_REQ,        // Field access request
  input  wire logic                   I_GPA_LOAD,   // Hardware loads address
  input  wire logic [63:0]            I_GPA_VALUE,  // Address to load
  output var  vmcfm_pkg::vmcfm_rsp_t  O_RSP         // Registered answer
);

  // ---------------------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------------------
  vmcfm_pkg::vmcfm_dec_t dec;

  vmcfm_decode u_decode (
    .i_encoding (I_REQ.encoding),
    .i_caps     (I_CAPS),
    .o_dec      (dec)
  );

  // ---------------------------------------------------------------------------
  // Field storage and answer
  // ---------------------------------------------------------------------------
  logic [63:0]           field_q [vmcfm_pkg::NUM_SLOTS];
  logic [63:0]           field_d [vmcfm_pkg::NUM_SLOTS];
  vmcfm_pkg::vmcfm_rsp_t rsp_q;
  vmcfm_pkg::vmcfm_rsp_t rsp_d;
  logic                  ok;
  logic [63:0]           cur;

  always_comb begin
    field_d = field_q;
    rsp_d   = '0;
    ok      = dec.hit & dec.exists;
    cur     = field_q[dec.slot];
    if (I_REQ.valid) begin
      rsp_d.valid     = 1'b1;
      rsp_d.high_half = dec.high_half;
      rsp_d.fclass    = dec.fclass;
      // Writes to read-only data are refused like a missing field, so that
      // software cannot forge the hardware-loaded address.
      rsp_d.error     = ~ok | (I_REQ.write & dec.read_only);
      if (!rsp_d.error) begin
        if (I_REQ.write) begin
          if (dec.high_half) begin
            field_d[dec.slot] = {I_REQ.wdata[31:0], cur[31:0]};
          end else begin
            field_d[dec.slot] = I_REQ.wdata;
          end
        end else if (dec.high_half) begin
          rsp_d.rdata = {32'h0000_0000, cur[63:32]};
        end else begin
          rsp_d.rdata = cur;
        end
      end
    end
    // The hardware load wins over a same-cycle access to the same field.
    if (I_GPA_LOAD && I_CAPS.extended_page_tables) begin
      field_d[vmcfm_pkg::SLOT_GPA] = I_GPA_VALUE;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      for (int i = 0; i < vmcfm_pkg::NUM_SLOTS; i++) begin
        field_q[i] <= vmcfm_pkg::FIELD_RESET;
      end
      rsp_q <= '0;
    end else begin
      field_q <= field_d;
      rsp_q   <= rsp_d;
    end
  end

  assign O_RSP = rsp_q;

endmodule // vmcfm_field_map

`default_nettype wire

// ===== vmcfm_field_map_assertions.sv
/*
  Checker for the field map: answer class, refusals and half access.
  Assumes it is bound to the top module and sees only its ports.
*/
`default_nettype none

module vmcfm_field_map_checker (
  input wire logic                   I_CLK,       // Clock
  input wire logic                   I_RST_N,     // Reset, low
  input wire vmcfm_pkg::vmcfm_caps_t I_CAPS,      // Settings
  input wire vmcfm_pkg::vmcfm_req_t  I_REQ,       // Request
  input wire logic                   I_GPA_LOAD,  // Address load
  input wire logic [63:0]            I_GPA_VALUE, // Address value
  input wire vmcfm_pkg::vmcfm_rsp_t  O_RSP        // Answer
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);

  ro_class_a: assert property (I_REQ.valid && I_REQ.encoding[31:10] == 22'h9
    |=> O_RSP.fclass == vmcfm_pkg::VMCFM_CLS_RO_DATA) else $error("read-only class wrong");
  guest_class_a: assert property (I_REQ.valid && I_REQ.encoding[31:10] == 22'hA
    |=> O_RSP.fclass == vmcfm_pkg::VMCFM_CLS_GUEST) else $error("guest class wrong");
  host_class_a: assert property (I_REQ.valid && I_REQ.encoding[31:10] == 22'hB
    |=> O_RSP.fclass == vmcfm_pkg::VMCFM_CLS_HOST) else $error("host class wrong");
  narrow_refused_a: assert property (I_REQ.valid && I_REQ.encoding[14:13] == 2'h2
    |=> O_RSP.valid && O_RSP.error) else $error("32-bit encoding not refused");
  ro_write_a: assert property (I_REQ.valid && I_REQ.write
    && I_REQ.encoding[31:1] == 31'h1200 |=> O_RSP.error) else $error("address write taken");
  link_present_a: assert property (I_REQ.valid && I_REQ.encoding[31:2] == 30'hA00
    |=> O_RSP.valid && !O_RSP.error) else $error("link or debug copy refused");
  perf_absent_a: assert property (I_REQ.valid && !I_CAPS.entry_load_perf_global
    && I_REQ.encoding[31:1] == 31'h1404 |=> O_RSP.error) else $error("perf copy not refused");
  refused_empty_a: assert property (O_RSP.valid && O_RSP.error
    |-> O_RSP.rdata == 64'h0) else $error("refused access returned data");
  high_upper_a: assert property (I_REQ.valid && !I_REQ.write && I_REQ.encoding[0]
    |=> O_RSP.rdata[63:32] == 32'h0) else $error("high read upper half not zero");
  high_flag_a: assert property (I_REQ.valid ##1 !O_RSP.error
    |-> O_RSP.high_half == $past(I_REQ.encoding[0])) else $error("half flag wrong");
endmodule // vmcfm_field_map_checker

`default_nettype wire

// ===== vmcfm_requester.sv
/*
  Requester model standing in for the instruction logic that accesses fields.
  Assumes its tasks are entered just after a falling clock edge.
*/
`default_nettype none

module vmcfm_requester (
  input  wire logic                  i_clk, // Clock
  input  wire vmcfm_pkg::vmcfm_rsp_t i_rsp, // Answer
  output var  vmcfm_pkg::vmcfm_req_t o_req  // Request
);
  timeunit 1ns;
  timeprecision 1ns;

  initial o_req = '0;

  // Requests go back to back; the answer is taken at the falling edge, half a cycle after the edge.
  task automatic access(input logic wr, input logic [31:0] enc, input logic [63:0] wd,
                        output vmcfm_pkg::vmcfm_rsp_t rsp);
    o_req = '{valid: 1'b1, write: wr, encoding: enc, wdata: wd};
    @(posedge i_clk);
    @(negedge i_clk);
    rsp = i_rsp;
  endtask

  // A cycle passes so the next request never lands in the same time step.
  task automatic idle();
    o_req.valid = 1'b0;
    @(negedge i_clk);
  endtask
endmodule // vmcfm_requester

`default_nettype wire

// ===== vmcfm_field_map_test.sv
/*
  Self-checking bench for the field map: storage, existence, refusals.
  Assumes the package, design, checker and requester are compiled first.
*/
`default_nettype none

module vmcfm_field_map_test;
  timeunit 1ns;
  timeprecision 1ns;

  logic                   i_clk;
  logic                   i_rst_n;
  vmcfm_pkg::vmcfm_caps_t i_caps;
  vmcfm_pkg::vmcfm_req_t  i_req;
  logic                   i_gpa_load;
  logic [63:0]            i_gpa_value;
  vmcfm_pkg::vmcfm_rsp_t  o_rsp;
  vmcfm_pkg::vmcfm_rsp_t  r;
  int                     errors;
  int                     n_checks;
  logic [15:0] enc_tab [17] = '{16'h2040, 16'h2042, 16'h2044, 16'h2400, 16'h2800,
    16'h2802, 16'h2804, 16'h2806, 16'h2808, 16'h280A, 16'h280C, 16'h280E, 16'h2810,
    16'h2812, 16'h2814, 16'h2816, 16'h2818};
  logic [15:0] cap_tab [17] = '{16'h8000, 16'h4000, 16'h2000, 16'h1000, 16'h0000,
    16'h0000, 16'h0C00, 16'h0300, 16'h0080, 16'h1000, 16'h1000, 16'h1000, 16'h1000,
    16'h0060, 16'h0018, 16'h0006, 16'h0001};

  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  vmcfm_field_map dut_u (.I_CLK(i_clk), .I_RST_N(i_rst_n), .I_CAPS(i_caps), .I_REQ(i_req),
    .I_GPA_LOAD(i_gpa_load), .I_GPA_VALUE(i_gpa_value), .O_RSP(o_rsp));
  vmcfm_requester req_u (.i_clk(i_clk), .i_rsp(o_rsp), .o_req(i_req));

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic acc(input logic wr, input logic [31:0] enc, input logic [63:0] wd);
    req_u.access(wr, enc, wd, r);
    chk(64'(r.valid), 64'h1);
  endtask

  function automatic logic [63:0] pat(input int i);
    return {32'hC0DE_0000 | 32'(i), 32'h0000_BEE0 + 32'(i)};
  endfunction

  task automatic t_store();
    logic [31:0] e;
    logic [63:0] v;
    for (int i = 0; i < 17; i++) begin
      e = 32'(enc_tab[i]);
      acc(1'b0, e, 64'h0);
      chk(r.rdata, vmcfm_pkg::FIELD_RESET);
      chk(64'(r.fclass), 64'(e[11:10]));
      if (i != 3) acc(1'b1, e, pat(i));
    end
    for (int i = 0; i < 17; i++) begin
      e = 32'(enc_tab[i]);
      v = pat(i);
      if (i != 3) begin
        acc(1'b0, e, 64'h0);
        chk(r.rdata, v);
        chk(64'(r.high_half), 64'h0);
        acc(1'b0, e + 32'h1, 64'h0);
        chk(r.rdata, {32'h0, v[63:32]});
        chk(64'(r.high_half), 64'h1);
        acc(1'b1, e + 32'h1, 64'hFFFF_FFFF_0000_0000 | 64'(i));
        acc(1'b0, e, 64'h0);
        chk(r.rdata, {32'(i), v[31:0]});
      end
    end
    req_u.idle();
    $display("TEST t_store done");
  endtask

  // Each field is tried under every single setting, then written with none set.
  task automatic t_exist();
    logic [31:0] e;
    logic [63:0] v;
    for (int i = 0; i < 17; i++) begin
      e = 32'(enc_tab[i]);
      for (int b = 0; b < 17; b++) begin
        i_caps = (b == 16) ? '0 : vmcfm_pkg::vmcfm_caps_t'(16'h1 << b);
        acc(b == 16, e, 64'hFFFF_FFFF_FFFF_FFFF);
        chk(64'(r.error), 64'(cap_tab[i] != 16'h0 && (b == 16 || !cap_tab[i][b])));
      end
    end
    i_caps = '1;
    for (int i = 0; i < 17; i++) begin
      v = pat(i);
      acc(1'b0, 32'(enc_tab[i]), 64'h0);
      v = (i == 3) ? 64'h0 : {32'(i), v[31:0]};
      chk(r.rdata, (cap_tab[i] == 16'h0) ? 64'hFFFF_FFFF_FFFF_FFFF : v);
    end
    req_u.idle();
    $display("TEST t_exist done");
  endtask

  task automatic t_gpa();
    i_gpa_load = 1'b1;
    i_gpa_value = 64'hFEDC_BA98_7654_3210;
    @(negedge i_clk);
    i_gpa_load = 1'b0;
    acc(1'b0, 32'h0000_2401, 64'h0);
    chk(r.rdata, 64'h0000_0000_FEDC_BA98);
    acc(1'b1, 32'h0000_2400, 64'h0);
    chk(64'(r.error), 64'h1);
    acc(1'b0, 32'h0000_2400, 64'h0);
    chk(r.rdata, 64'hFEDC_BA98_7654_3210);
    // Without page-table support the hardware load must leave the field alone.
    i_caps.extended_page_tables = 1'b0;
    i_gpa_load = 1'b1;
    i_gpa_value = 64'h0123_4567_89AB_CDEF;
    req_u.idle();
    i_gpa_load = 1'b0;
    i_caps = '1;
    acc(1'b0, 32'h0000_2400, 64'h0);
    chk(r.rdata, 64'hFEDC_BA98_7654_3210);
    req_u.idle();
    chk(64'(o_rsp.valid), 64'h0);
    $display("TEST t_gpa done");
  endtask

  task automatic t_refuse();
    logic [31:0] bad [5] = '{32'h0000_2046, 32'h0000_281A, 32'h0000_2C00,
      32'h0000_4800, 32'h0000_2402};
    for (int k = 0; k < 5; k++) begin
      acc(1'b0, bad[k], 64'h0);
      chk(64'(r.error), 64'h1);
      chk(64'(r.fclass), 64'(bad[k][11:10]));
    end
    req_u.idle();
    $display("TEST t_refuse done");
  endtask

  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    errors = 0;
    n_checks = 0;
    i_rst_n = 1'b0;
    i_caps = '1;
    i_gpa_load = 1'b0;
    i_gpa_value = 64'h0;
    repeat (3) @(negedge i_clk);
    i_rst_n = 1'b1;
    @(negedge i_clk);
    t_store();
    t_exist();
    t_gpa();
    t_refuse();
    report_and_stop();
  end
endmodule // vmcfm_field_map_test

bind vmcfm_field_map vmcfm_field_map_checker chk_u (.I_CLK(I_CLK), .I_RST_N(I_RST_N),
  .I_CAPS(I_CAPS), .I_REQ(I_REQ), .I_GPA_LOAD(I_GPA_LOAD), .I_GPA_VALUE(I_GPA_VALUE),
  .O_RSP(O_RSP));

`default_nettype wire
